// *** testbench/mmrd_decoder_bench.sv ***
// Purpose: Self-checking bench for the memory decoder.
// Assumes: Inputs change on the falling edge.
// Notes: Flash filled through the preload port.
`timescale 1ns/100ps
module mmrd_decoder_bench
   import mmrd_pkg::*;
;
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
   logic clk_i = 0, sys_rst_i = 1, req_i = 0, we_i = 0, remap_wr_i = 0, remap_flash_i = 1;
   mmrd_size_t size_i = MMRD_SZ_WORD;
   logic [31:0] addr_i = 0, wdata_i = 0, rdata_o, mmr_addr_o, mmr_wdata_o, mmr_rdata_i, rd;
   logic wait_o, ready_o, err_o, remap_o, boot_page_o, mmr_sel_o, mmr_en_o, mmr_we_o, er;
   logic [7:0] flash_page_o;
   logic [3:0] mmr_be_o;
   logic fl_load_i = 0, fl_load_bank_i = 0;
   mmrd_fl_idx_t fl_load_idx_i = 0;
   logic [15:0] fl_load_data_i = 0;
   int error_cnt = 0, cmp_count = 0, cyc = 0, lt;
   always #5 clk_i = ~clk_i;
   mmrd_decoder uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .we_i(we_i), .size_i(size_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wait_o(wait_o), .ready_o(ready_o), .err_o(err_o),
      .rdata_o(rdata_o), .remap_wr_i(remap_wr_i), .remap_flash_i(remap_flash_i), .remap_o(remap_o),
      .flash_page_o(flash_page_o), .boot_page_o(boot_page_o), .mmr_sel_o(mmr_sel_o), .mmr_en_o(mmr_en_o),
      .mmr_we_o(mmr_we_o), .mmr_addr_o(mmr_addr_o), .mmr_wdata_o(mmr_wdata_o), .mmr_be_o(mmr_be_o),
      .mmr_rdata_i(mmr_rdata_i), .fl_load_i(fl_load_i), .fl_load_bank_i(fl_load_bank_i),
      .fl_load_idx_i(fl_load_idx_i), .fl_load_data_i(fl_load_data_i));
   mmrd_periph_model pm (.clk_i(clk_i), .sel_i(mmr_sel_o), .en_i(mmr_en_o), .we_i(mmr_we_o),
      .addr_i(mmr_addr_o), .wdata_i(mmr_wdata_o), .be_i(mmr_be_o), .rdata_o(mmr_rdata_i));
   ////////////////////////////////////////////////////////////
   task summarize;
      if (error_cnt == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         summarize();
      end
   end
   // One bus access; lt counts wait cycles between the take edge and ready_o
   task automatic acc(input logic w, input mmrd_size_t s, input logic [31:0] a, input logic [31:0] d);
      @(negedge clk_i);
      req_i = 1; we_i = w; size_i = s; addr_i = a; wdata_i = d;
      @(negedge clk_i);
      req_i = 0;
      lt = 0;
      while (ready_o !== 1'b1 && lt < 8) begin
         @(negedge clk_i);
         lt++;
      end
      `CHK("ready", 1'b1, ready_o)
      rd = rdata_o;
      er = err_o;
   endtask
   task automatic ld(input logic b, input mmrd_fl_idx_t i, input logic [15:0] v);
      @(negedge clk_i);
      fl_load_i = 1; fl_load_bank_i = b; fl_load_idx_i = i; fl_load_data_i = v;
      @(negedge clk_i);
      fl_load_i = 0;
   endtask
   task automatic set_remap(input logic v);
      @(negedge clk_i);
      remap_wr_i = 1; remap_flash_i = v;
      @(negedge clk_i);
      remap_wr_i = 0;
      `CHK("remap", v, remap_o)
   endtask
   ////////////////////////////////////////////////////////////
   task t_reset;
      `CHK("remap", 1'b1, remap_o)
      `CHK("rdata", 32'h0, rdata_o)
      `CHK("sel", 1'b0, mmr_sel_o)
   endtask
   task t_flash;
      ld(1, 15'h0000, 16'h1111); ld(1, 15'h0001, 16'h2222); ld(1, 15'h0100, 16'h5A3C);
      ld(0, 15'h0002, 16'hCAFE); ld(0, 15'h0003, 16'hBEEF); ld(0, 15'h7C00, 16'hB007);
      acc(0, MMRD_SZ_WORD, 32'h0009_0004, 0);
      `CHK("fl word", 32'hBEEFCAFE, rd)
      `CHK("fl lat", 1, lt)
      acc(0, MMRD_SZ_WORD, 32'h0000_0000, 0);
      `CHK("alias0", 32'h22221111, rd)
      acc(0, MMRD_SZ_HALF, 32'h0001_F800, 0);
      `CHK("alias1", 32'hB007, rd)
      acc(0, MMRD_SZ_BYTE, 32'h0008_0201, 0);
      `CHK("fl byte", 32'h5A, rd)
      `CHK("page", 8'h01, flash_page_o)
      `CHK("boot", 1'b0, boot_page_o)
      acc(0, MMRD_SZ_HALF, 32'h0009_F800, 0);
      `CHK("boot rd", 32'hB007, rd)
      `CHK("fl half lat", 0, lt)
      `CHK("page", 8'hFC, flash_page_o)
      `CHK("boot", 1'b1, boot_page_o)
      acc(1, MMRD_SZ_HALF, 32'h0008_0000, 32'h0000_FFFF);
      `CHK("fl wr err", 1'b1, er)
      acc(0, MMRD_SZ_HALF, 32'h0008_0000, 0);
      `CHK("fl kept", 32'h1111, rd)
   endtask
   task t_sram;
      acc(1, MMRD_SZ_WORD, 32'h0001_1FFC, 32'h1122_3344);
      for (int i = 0; i < 4; i++) begin
         acc(0, MMRD_SZ_BYTE, 32'h0001_1FFC + i, 0);
         `CHK("sram byte", 32'h1122_3344 >> (8 * i) & 32'hFF, rd)
      end
      acc(0, MMRD_SZ_HALF, 32'h0001_1FFE, 0);
      `CHK("sram half", 32'h1122, rd)
      acc(1, MMRD_SZ_BYTE, 32'h0001_1FFD, 32'h0000_00EE);
      acc(0, MMRD_SZ_WORD, 32'h0001_1FFC, 0);
      `CHK("sram word", 32'h1122_EE44, rd)
      `CHK("sram lat", 0, lt)
   endtask
   task t_remap;
      set_remap(0);
      acc(0, MMRD_SZ_WORD, 32'h0000_1FFC, 0);
      `CHK("sram at 0", 32'h1122_EE44, rd)
      acc(0, MMRD_SZ_WORD, 32'h0000_2000, 0);
      `CHK("past sram", 1'b1, er)
      set_remap(1);
      acc(0, MMRD_SZ_WORD, 32'h0000_0000, 0);
      `CHK("flash at 0", 32'h22221111, rd)
      set_remap(0);
      @(negedge clk_i);
      sys_rst_i = 1;
      @(negedge clk_i);
      sys_rst_i = 0;
      `CHK("re-reset", 1'b1, remap_o)
   endtask
   task t_mmr;
      acc(1, MMRD_SZ_WORD, 32'hFFFF_0044, 32'hA5A5_0F0F);
      `CHK("mmr wr err", 1'b0, er)
      acc(1, MMRD_SZ_BYTE, 32'hFFFF_0045, 32'h0000_00EE);
      acc(0, MMRD_SZ_WORD, 32'hFFFF_0044, 0);
      `CHK("mmr rd", 32'hA5A5_EE0F, rd)
      `CHK("mmr lat", 2, lt)
      acc(0, MMRD_SZ_WORD, 32'h2000_0000, 0);
      `CHK("unmapped", 1'b1, er)
      `CHK("kept rd", 32'hA5A5_EE0F, rd)
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      sys_rst_i = 0;
      t_reset();
      t_flash();
      t_sram();
      t_remap();
      t_mmr();
      summarize();
   end
endmodule

// *** testbench/mmrd_decoder_monitor.sv ***
// Purpose: Port checks for the memory decoder.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every decoder instance.
`timescale 1ns/100ps
module mmrd_decoder_monitor
   import mmrd_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire mmrd_size_t size_i,
   input wire logic [31:0] addr_i,
   input wire logic wait_o,
   input wire logic ready_o,
   input wire logic err_o,
   input wire logic remap_wr_i,
   input wire logic remap_flash_i,
   input wire logic remap_o,
   input wire logic boot_page_o,
   input wire logic mmr_sel_o,
   input wire logic mmr_en_o
);
   logic take;
   logic fl_rg;
   logic boot_rg;
   assign take = req_i && !wait_o;
   assign fl_rg = addr_i[31:17] == 15'h0004;
   assign boot_rg = addr_i[31:11] == 21'h00013F;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence mmr_setup;
      mmr_sel_o && !mmr_en_o && wait_o;
   endsequence
   sequence mmr_access;
      mmr_sel_o && mmr_en_o && !ready_o;
   endsequence
   ////////////////////////////////////////////////////////////
   reset_state_a: assert property (disable iff (1'b0)
      sys_rst_i |=> remap_o && !wait_o && !ready_o && !err_o) else $error("reset state wrong");
   remap_clear_a: assert property (remap_wr_i && !remap_flash_i |=> !remap_o)
      else $error("remap bit not cleared");
   remap_hold_a: assert property (!remap_wr_i |=> $stable(remap_o))
      else $error("remap bit moved");
   flash_word_a: assert property (take && !we_i && size_i == MMRD_SZ_WORD && fl_rg
      |=> (wait_o && !ready_o) ##1 (ready_o && !wait_o)) else $error("flash word timing");
   flash_half_a: assert property (take && !we_i && size_i != MMRD_SZ_WORD && size_i != 2'h3 && fl_rg
      |=> ready_o && !wait_o) else $error("flash half timing");
   sram_single_a: assert property (take && addr_i[31:13] == 19'h00008 |=> ready_o && !wait_o && !err_o)
      else $error("sram timing");
   periph_two_a: assert property (take && addr_i[31:16] == 16'hFFFF
      |=> mmr_setup ##1 mmr_access ##1 (ready_o && !mmr_sel_o)) else $error("peripheral timing");
   flash_write_a: assert property (take && we_i && fl_rg |=> ready_o && err_o)
      else $error("flash write accepted");
   unmapped_err_a: assert property (take && addr_i[31:20] == 12'h200 |=> ready_o && err_o)
      else $error("unmapped not refused");
   err_ready_a: assert property (err_o |-> ready_o)
      else $error("error without ready");
   wait_bound_a: assert property (wait_o |-> ##[1:2] ready_o)
      else $error("wait too long");
   boot_flag_a: assert property (take && !we_i && boot_rg |-> ##[1:2] boot_page_o)
      else $error("boot page flag");
endmodule
bind mmrd_decoder mmrd_decoder_monitor mon (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .we_i(we_i),
   .size_i(size_i), .addr_i(addr_i), .wait_o(wait_o), .ready_o(ready_o), .err_o(err_o),
   .remap_wr_i(remap_wr_i), .remap_flash_i(remap_flash_i), .remap_o(remap_o), .boot_page_o(boot_page_o),
   .mmr_sel_o(mmr_sel_o), .mmr_en_o(mmr_en_o));

// *** testbench/mmrd_periph_model.sv ***
// Purpose: Peripheral slave with 16 word registers.
// Assumes: Setup then access cycle from the decoder.
// Notes: Read data is scrambled while idle.
`timescale 1ns/100ps
module mmrd_periph_model (
   input wire logic clk_i,
   input wire logic sel_i,
   input wire logic en_i,
   input wire logic we_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] be_i,
   output logic [31:0] rdata_o
);
   logic [31:0] regs [16];
   logic [31:0] last_q;
   always_ff @(posedge clk_i) begin
      last_q <= rdata_o;
      if (sel_i && en_i && we_i) begin
         for (int b = 0; b < 4; b++) begin
            if (be_i[b]) begin
               regs[addr_i[5:2]][b*8 +: 8] <= wdata_i[b*8 +: 8];
            end
         end
      end
   end
   // Only the access cycle carries real data
   assign rdata_o = (sel_i && en_i && !we_i) ? regs[addr_i[5:2]] : ~last_q;
endmodule

// *** verilog/mmrd_decoder.sv ***
// Purpose: Memory system behind the processor bus: SRAM, two flash banks, remap.
// Assumes: One request at a time; req_i pulses only while wait_o is low.
// Notes: Read data is right-justified; write data sits in the low bits.
`timescale 1ns/100ps
`include "mmrd_regs.svh"
module mmrd_decoder
   import mmrd_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic req_i,
   input wire logic we_i,
   input wire mmrd_size_t size_i,
   input wire logic [31:0] addr_i,
   input wire logic [31:0] wdata_i,
   output logic wait_o,
   output logic ready_o,
   output logic err_o,
   output logic [31:0] rdata_o,
   input wire logic remap_wr_i,
   input wire logic remap_flash_i,
   output logic remap_o,
   output logic [7:0] flash_page_o,
   output logic boot_page_o,
   output logic mmr_sel_o,
   output logic mmr_en_o,
   output logic mmr_we_o,
   output logic [31:0] mmr_addr_o,
   output logic [31:0] mmr_wdata_o,
   output logic [3:0] mmr_be_o,
   input wire logic [31:0] mmr_rdata_i,
   input wire logic fl_load_i,
   input wire logic fl_load_bank_i,
   input wire mmrd_fl_idx_t fl_load_idx_i,
   input wire logic [15:0] fl_load_data_i
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic in_sram(input logic [31:0] p);
      return (p >= `MMRD_SRAM_BASE) && (p < `MMRD_SRAM_BASE + `MMRD_SRAM_BYTES);
   endfunction
   // Alias window at zero; native SRAM stays reachable inside it
   function automatic logic [31:0] phys_of(input logic [31:0] a, input logic rmp);
      logic [31:0] p;
      p = a;
      if (a < `MMRD_ALIAS_BYTES && !in_sram(a)) begin
         if (rmp) begin
            p = a + `MMRD_FL1_BASE;
         end else begin
            p = a + `MMRD_SRAM_BASE;
         end
      end
      return p;
   endfunction

   function automatic mmrd_region_t region_of(input logic [31:0] p);
      mmrd_region_t r;
      r = MMRD_RG_NONE;
      if (in_sram(p)) begin
         r = MMRD_RG_SRAM;
      end else if (p >= `MMRD_FL1_BASE && p < `MMRD_FL0_BASE) begin
         r = MMRD_RG_FL1;
      end else if (p >= `MMRD_FL0_BASE && p < `MMRD_FL_END) begin
         r = MMRD_RG_FL0;
      end else if (p >= `MMRD_MMR_BASE) begin
         r = MMRD_RG_MMR;
      end
      return r;
   endfunction

   // Offset of the lowest addressed byte, aligned to the size
   function automatic logic [1:0] align_off(input mmrd_size_t sz, input logic [1:0] off);
      logic [1:0] o;
      o = 2'h0;
      unique case (sz)
         MMRD_SZ_BYTE: o = off;
         MMRD_SZ_HALF: o = {off[1], 1'h0};
         default: o = 2'h0;
      endcase
      return o;
   endfunction

   // Lowest address in the lowest lane
   function automatic logic [31:0] rd_fmt(input logic [31:0] w, input logic [1:0] off, input mmrd_size_t sz);
      logic [31:0] s;
      logic [31:0] r;
      s = w >> {off, 3'h0};
      unique case (sz)
         MMRD_SZ_BYTE: r = {24'h00_0000, s[7:0]};
         MMRD_SZ_HALF: r = {16'h0000, s[15:0]};
         default: r = w;
      endcase
      return r;
   endfunction

   function automatic logic [3:0] be_of(input mmrd_size_t sz, input logic [1:0] off);
      logic [3:0] b;
      unique case (sz)
         MMRD_SZ_BYTE: b = 4'h1 << off;
         MMRD_SZ_HALF: b = 4'h3 << off;
         default: b = 4'hF;
      endcase
      return b;
   endfunction

   function automatic logic [7:0] page_of(input logic [31:0] p);
      logic [31:0] t;
      t = (p - `MMRD_FL1_BASE) >> `MMRD_PAGE_SHIFT;
      return t[7:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Decode
   mmrd_state_t state_q, state_d;
   mmrd_region_t rgn_w;
   mmrd_size_t size_q;
   mmrd_fl_idx_t hi_idx_q, fl_idx_w, fl_rd_idx_w;
   logic remap_q, take_w, is_fl_w, fl_split_w, bank0_q, we_q, ready_q, err_q, boot_q, fl_sel0_w, sram_we_w;
   logic [1:0] off_w, off_q;
   logic [3:0] mmr_be_q;
   logic [7:0] page_q;
   logic [15:0] lo_q, b0_data_w, b1_data_w, fl_half_w;
   logic [31:0] phys_w, rdata_q, mmr_addr_q, mmr_wdata_q, sram_rdata_w;
   assign phys_w = phys_of(addr_i, remap_q);
   assign rgn_w = region_of(phys_w);
   assign off_w = align_off(size_i, addr_i[1:0]);
   assign take_w = req_i && (state_q == MMRD_ST_IDLE);
   assign is_fl_w = (rgn_w == MMRD_RG_FL0) || (rgn_w == MMRD_RG_FL1);
   assign fl_split_w = is_fl_w && !we_i && (size_i != MMRD_SZ_BYTE) && (size_i != MMRD_SZ_HALF);
   assign fl_idx_w = phys_w[15:1];

   ////////////////////////////////////////////////////////////////////////
   // Memories
   // Word access reads the even halfword first
   always_comb begin
      if (state_q == MMRD_ST_FL_HI) begin
         fl_rd_idx_w = hi_idx_q;
         fl_sel0_w = bank0_q;
      end else begin
         fl_rd_idx_w = fl_split_w ? {fl_idx_w[14:1], 1'h0} : fl_idx_w;
         fl_sel0_w = (rgn_w == MMRD_RG_FL0);
      end
   end
   assign fl_half_w = fl_sel0_w ? b0_data_w : b1_data_w;
   mmrd_flash_bank u_bank0 (
      .clk_i(clk_i),
      .load_i(fl_load_i && !fl_load_bank_i),
      .load_idx_i(fl_load_idx_i),
      .load_data_i(fl_load_data_i),
      .rd_idx_i(fl_rd_idx_w),
      .rd_data_o(b0_data_w)
   );
   mmrd_flash_bank u_bank1 (
      .clk_i(clk_i),
      .load_i(fl_load_i && fl_load_bank_i),
      .load_idx_i(fl_load_idx_i),
      .load_data_i(fl_load_data_i),
      .rd_idx_i(fl_rd_idx_w),
      .rd_data_o(b1_data_w)
   );
   assign sram_we_w = take_w && we_i && (rgn_w == MMRD_RG_SRAM);
   mmrd_sram u_sram (
      .clk_i(clk_i),
      .we_i(sram_we_w),
      .be_i(be_of(size_i, off_w)),
      .idx_i(phys_w[12:2]),
      .wdata_i(wdata_i << {off_w, 3'h0}),
      .rdata_o(sram_rdata_w)
   );

   ////////////////////////////////////////////////////////////////////////
   // Remap control
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         remap_q <= `MMRD_REMAP_RST;
      end else if (remap_wr_i) begin
         remap_q <= remap_flash_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         MMRD_ST_IDLE: begin
            if (take_w && fl_split_w) begin
               state_d = MMRD_ST_FL_HI;
            end else if (take_w && rgn_w == MMRD_RG_MMR) begin
               state_d = MMRD_ST_MMR_SET;
            end
         end
         MMRD_ST_FL_HI: state_d = MMRD_ST_IDLE;
         MMRD_ST_MMR_SET: state_d = MMRD_ST_MMR_ACC;
         MMRD_ST_MMR_ACC: state_d = MMRD_ST_IDLE;
         default: state_d = MMRD_ST_IDLE;
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_q <= MMRD_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         lo_q <= 16'h0000;
         hi_idx_q <= 15'h0000;
         bank0_q <= 1'h0;
         off_q <= 2'h0;
         size_q <= MMRD_SZ_BYTE;
         we_q <= 1'h0;
      end else if (take_w) begin
         lo_q <= fl_half_w;
         hi_idx_q <= {fl_idx_w[14:1], 1'h1};
         bank0_q <= (rgn_w == MMRD_RG_FL0);
         off_q <= off_w;
         size_q <= size_i;
         we_q <= we_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Answer
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ready_q <= 1'h0;
         err_q <= 1'h0;
         rdata_q <= 32'h0000_0000;
      end else begin
         ready_q <= 1'h0;
         err_q <= 1'h0;
         if (take_w) begin
            unique case (rgn_w)
               MMRD_RG_SRAM: begin
                  ready_q <= 1'h1;
                  if (!we_i) begin
                     rdata_q <= rd_fmt(sram_rdata_w, off_w, size_i);
                  end
               end
               MMRD_RG_FL0, MMRD_RG_FL1: begin
                  if (we_i) begin
                     ready_q <= 1'h1;
                     err_q <= 1'h1;
                  end else if (!fl_split_w) begin
                     ready_q <= 1'h1;
                     rdata_q <= rd_fmt({fl_half_w, fl_half_w}, off_w, size_i);
                  end
               end
               MMRD_RG_MMR: ready_q <= 1'h0;
               default: begin
                  ready_q <= 1'h1;
                  err_q <= 1'h1;
               end
            endcase
         end else if (state_q == MMRD_ST_FL_HI) begin
            ready_q <= 1'h1;
            rdata_q <= {fl_half_w, lo_q};
         end else if (state_q == MMRD_ST_MMR_ACC) begin
            ready_q <= 1'h1;
            if (!we_q) begin
               rdata_q <= rd_fmt(mmr_rdata_i, off_q, size_q);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flash page tracking
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         page_q <= 8'h00;
         boot_q <= 1'h0;
      end else if (take_w && is_fl_w) begin
         page_q <= page_of(phys_w);
         boot_q <= (phys_w >= `MMRD_BOOT_BASE) && (rgn_w == MMRD_RG_FL0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Peripheral register port
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         mmr_addr_q <= 32'h0000_0000;
         mmr_wdata_q <= 32'h0000_0000;
         mmr_be_q <= 4'h0;
      end else if (take_w && rgn_w == MMRD_RG_MMR) begin
         mmr_addr_q <= {phys_w[31:2], 2'h0};
         mmr_wdata_q <= wdata_i << {off_w, 3'h0};
         mmr_be_q <= be_of(size_i, off_w);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign wait_o = (state_q != MMRD_ST_IDLE);
   assign ready_o = ready_q;
   assign err_o = err_q;
   assign rdata_o = rdata_q;
   assign remap_o = remap_q;
   assign flash_page_o = page_q;
   assign boot_page_o = boot_q;
   assign mmr_sel_o = (state_q == MMRD_ST_MMR_SET) || (state_q == MMRD_ST_MMR_ACC);
   assign mmr_en_o = (state_q == MMRD_ST_MMR_ACC);
   assign mmr_we_o = mmr_sel_o && we_q;
   assign mmr_addr_o = mmr_addr_q;
   assign mmr_wdata_o = mmr_wdata_q;
   assign mmr_be_o = mmr_be_q;

endmodule

// *** verilog/mmrd_flash_bank.sv ***
// Purpose: One nonvolatile code array bank, 32k halfwords.
// Assumes: Contents preloaded through the load port.
// Notes: Processor writes never reach the array.
`timescale 1ns/100ps
module mmrd_flash_bank
   import mmrd_pkg::*;
(
   input wire logic clk_i,
   input wire logic load_i,
   input wire mmrd_fl_idx_t load_idx_i,
   input wire logic [15:0] load_data_i,
   input wire mmrd_fl_idx_t rd_idx_i,
   output logic [15:0] rd_data_o
);

   logic [15:0] mem_q [0:32767];

   always_ff @(posedge clk_i) begin
      if (load_i) begin
         mem_q[load_idx_i] <= load_data_i;
      end
   end

   assign rd_data_o = mem_q[rd_idx_i];

endmodule

// *** verilog/mmrd_pkg.sv ***
// Purpose: Types shared by the memory decoder files.
// Assumes: Nothing beyond the address header.
// Notes: Widths follow the array organisation.
package mmrd_pkg;

   typedef logic [10:0] mmrd_sram_idx_t;
   typedef logic [14:0] mmrd_fl_idx_t;

   typedef enum logic [1:0] {
      MMRD_SZ_BYTE = 2'h0,
      MMRD_SZ_HALF = 2'h1,
      MMRD_SZ_WORD = 2'h2
   } mmrd_size_t;

   typedef enum logic [2:0] {
      MMRD_RG_NONE = 3'h0,
      MMRD_RG_SRAM = 3'h1,
      MMRD_RG_FL0 = 3'h2,
      MMRD_RG_FL1 = 3'h3,
      MMRD_RG_MMR = 3'h4
   } mmrd_region_t;

   typedef enum logic [3:0] {
      MMRD_ST_IDLE = 4'h1,
      MMRD_ST_FL_HI = 4'h2,
      MMRD_ST_MMR_SET = 4'h4,
      MMRD_ST_MMR_ACC = 4'h8
   } mmrd_state_t;

endpackage

// *** verilog/mmrd_regs.svh ***
// Purpose: Address map and timing constants of the memory decoder.
// Assumes: Byte addresses on a 32-bit processor bus.
// Notes: Definitions only.
`ifndef MMRD_REGS_SVH
`define MMRD_REGS_SVH

// Fixed regions of the flat address space
`define MMRD_ALIAS_BYTES 32'h0002_0000
`define MMRD_SRAM_BASE 32'h0001_0000
`define MMRD_SRAM_BYTES 32'h0000_2000
`define MMRD_FL1_BASE 32'h0008_0000
`define MMRD_FL0_BASE 32'h0009_0000
`define MMRD_FL_END 32'h000A_0000
`define MMRD_BOOT_BASE 32'h0009_F800
`define MMRD_MMR_BASE 32'hFFFF_0000

// Flash page of 512 bytes
`define MMRD_PAGE_SHIFT 32'h0000_0009

// Remap bit after reset: flash mirrored at zero
`define MMRD_REMAP_RST 1'h1

// Access rates in kHz and cycles per access
`define MMRD_FL_KHZ_HALF 32'h0000_A334
`define MMRD_FL_KHZ_WORD 32'h0000_519A
`define MMRD_SRAM_KHZ 32'h0000_A334
`define MMRD_SYS_CYC 2'h1
`define MMRD_PER_CYC 2'h2

`endif

// *** verilog/mmrd_sram.sv ***
// Purpose: 8 kB SRAM array, 2k words of 32 bits.
// Assumes: Byte enables already placed on their lanes.
// Notes: Read is combinational from the flip-flop array.
`timescale 1ns/100ps
module mmrd_sram
   import mmrd_pkg::*;
(
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [3:0] be_i,
   input wire mmrd_sram_idx_t idx_i,
   input wire logic [31:0] wdata_i,
   output logic [31:0] rdata_o
);

   logic [31:0] mem_q [0:2047];

   always_ff @(posedge clk_i) begin
      for (int b = 0; b < 4; b++) begin
         if (we_i && be_i[b]) begin
            mem_q[idx_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
         end
      end
   end

   assign rdata_o = mem_q[idx_i];

endmodule
